/* File: sbt_pkg.sv */
// Constants and types shared by the sixteen-bit timer/counter files.
// Assumes one 25 MHz core clock and a byte-wide register port.
package sbt_pkg;

  // Register port widths.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Register offsets on the register port.
  localparam logic [7:0] ADDR_CORE_IRQ = 8'h0b;
  localparam logic [7:0] ADDR_FLAGS    = 8'h0c;
  localparam logic [7:0] ADDR_COUNT_LO = 8'h0e;
  localparam logic [7:0] ADDR_COUNT_HI = 8'h0f;
  localparam logic [7:0] ADDR_CONTROL  = 8'h10;
  localparam logic [7:0] ADDR_ENABLES  = 8'h8c;

  // Field positions in counter_control.
  localparam int CTL_RUN_BIT      = 0;
  localparam int CTL_SRC_BIT      = 1;
  localparam int CTL_SYNC_DIS_BIT = 2;
  localparam int CTL_OSC_EN_BIT   = 3;
  localparam int CTL_PS_LO_BIT    = 4;
  localparam int CTL_PS_HI_BIT    = 5;
  localparam logic [7:0] CTL_MASK = 8'h3f;

  // Field positions in the interrupt registers.
  localparam int CORE_GIE_BIT  = 7;
  localparam int CORE_PERIPHERAL_IRQ_ENABLE_BIT = 6;
  localparam int FLAG_OVF_BIT  = 0;
  localparam int ENA_OVF_BIT   = 0;

  // Reset value of control, count clear and wrap values, idle read value.
  localparam logic [7:0]  CONTROL_RESET = 8'h00;
  localparam logic [15:0] COUNT_ZERO    = 16'h0000;
  localparam logic [15:0] COUNT_MAX     = 16'hffff;
  localparam logic [7:0]  READ_IDLE     = 8'h00;

  // Compare mode code that raises the special event trigger.
  localparam logic [3:0] TRIGGER_MODE = 4'hb;

  // Timing: the instruction clock is the core clock divided by four.
  localparam int CLOCK_PERIOD_NS = 40;
  localparam int INSTR_PERIOD_NS = 160;
  localparam int INSTR_CYCLES    = INSTR_PERIOD_NS / CLOCK_PERIOD_NS;
  localparam logic [1:0] INSTR_LAST = 2'(INSTR_CYCLES - 1);

  // Prescaler counter width, enough for a divide by eight.
  localparam int PRESCALE_W = 3;

  // Edge qualifier after the counter is enabled in external mode.
  typedef enum logic {
    ARM_WAIT_FALL,
    ARM_READY
  } sbt_arm_type;

endpackage : sbt_pkg

/* File: sbt_prescaler.sv */
// Input prescaler of the sixteen-bit timer/counter: divides a tick stream by 1, 2, 4 or 8.
// Assumes ticks are one-cycle pulses on the core clock.
module sbt_prescaler (
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       tick,
  input  wire logic       clear,
  input  wire logic [1:0] select,
  output logic            out_tick
);
  import sbt_pkg::*;

  typedef struct packed {
    logic [PRESCALE_W-1:0] cnt;
  } sbt_pre_state_type;

  sbt_pre_state_type state;
  sbt_pre_state_type next_state;
  logic [PRESCALE_W-1:0] mask;

  // The low select bits of the counter must all be ones for a tick to pass.
  always_comb begin
    mask = PRESCALE_W'((4'h1 << select) - 4'h1);
    out_tick = tick && ((state.cnt & mask) == mask);
  end

  // Counter advances on each input tick and is cleared by a count write.
  always_comb begin
    next_state = state;
    if (reset || clear) begin
      next_state.cnt = '0;
    end else if (tick) begin
      next_state.cnt = state.cnt + PRESCALE_W'(1);
    end
  end

  // State register.
  always_ff @(posedge clock) begin
    state <= next_state;
  end

  a_clear_empties: assert property (@(posedge clock) clear |=> state.cnt == '0)
    else $error("prescaler kept its count after a count write");

endmodule : sbt_prescaler

/* File: sbt_timer.sv */
// Sixteen-bit timer/counter with prescaler, external clock input and trigger reset.
// Assumes a 25 MHz core clock, pins synchronous to it, and a byte register port.
//
// How it works
// - External mode counts rising edges of oscillator pin or external clock pin.
// - Synchronized mode resynchronizes after the prescaler; prescaler is a synchronous counter on the core clock.
// - Synchronized counting in sleep holds the count; prescaler keeps advancing.
// - Unsynchronized mode keeps counting in sleep and wakes the processor on overflow.
// - Unsynchronized counting is not offered as capture or compare time base.
// - Count byte reads always return a stable registered value.
// - Oscillator enable bit turns on the crystal amplifier, also in sleep.
// - Compare trigger with mode 1011 resets the count to zero.
// - Trigger reset is ignored while counting unsynchronized.
// - A count write in the trigger cycle wins over the trigger.
// - No reset clears the count; only compare triggers do.
// - Control clears on power-on reset only; other resets keep it.
// - Any write to either count byte clears the prescaler.
// - Count wraps from ffff to 0000 and latches the overflow flag.
// - Prescale field 00,01,10,11 divides by 1,2,4,8.
// - Internal source counts the instruction clock; sync bit is ignored.
// - After enabling external mode a falling edge must come before counting.
//
// The plain strobed port was left to the implementer.
module sbt_timer (
  input  wire logic                      clock,
  input  wire logic                      reset,
  input  wire logic                      other_reset,
  input  wire logic                      sleep,
  input  wire logic [sbt_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [sbt_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                      reg_write,
  input  wire logic                      reg_read,
  output logic      [sbt_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic                      ext_count_pin,
  input  wire logic                      osc_input_pin,
  input  wire logic [3:0]                compare_mode_select_one,
  input  wire logic                      compare_unit_one_trigger,
  input  wire logic [3:0]                compare_mode_select_two,
  input  wire logic                      compare_unit_two_trigger,
  output logic                           osc_amp_enable,
  output logic                           time_base_valid,
  output logic      [15:0]               time_base_count,
  output logic                           overflow_irq,
  output logic                           wake_request
);
  import sbt_pkg::*;

  typedef struct packed {
    logic [15:0]  count;
    logic [7:0]   control;
    logic         global_irq_enable;
    logic         peripheral_irq_enable;
    logic         overflow_flag;
    logic         overflow_irq_enable;
    logic [1:0]   instr_phase;
    logic         pin_last;
    sbt_arm_type  arm;
    logic [1:0]   sync_pipe;
    logic [7:0]   rdata;
  } sbt_state_type;

  sbt_state_type state;
  sbt_state_type next_state;

  logic       counter_run;
  logic       clock_source_select;
  logic       sync_disable;
  logic       osc_enable;
  logic [1:0] prescale_sel;
  logic       async_mode;
  logic       ext_enabled;
  logic       sel_pin;
  logic       pin_rise;
  logic       pin_fall;
  logic       ext_tick;
  logic       instr_tick;
  logic       pre_in;
  logic       pre_out;
  logic       count_inc;
  logic       trig_ok;
  logic       write_lo;
  logic       write_hi;
  logic       write_count;
  logic [7:0] count_hi;

  // Address match, used by every write and read decode.
  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [7:0] offset);
    hit = (addr == offset);
  endfunction : hit

  // A compare unit raises the special event only in its trigger mode.
  function automatic logic unit_trigger(input logic [3:0] mode, input logic trig);
    unit_trigger = trig && (mode == TRIGGER_MODE);
  endfunction : unit_trigger

  // Read multiplexer; unmapped addresses and reserved bits read as zero.
  function automatic logic [7:0] read_mux(input logic [ADDR_W-1:0] addr,
                                          input sbt_state_type s);
    logic [7:0] value;
    value = READ_IDLE;
    if (hit(addr, ADDR_COUNT_LO)) begin
      value = s.count[7:0];
    end else if (hit(addr, ADDR_COUNT_HI)) begin
      value = s.count[15:8];
    end else if (hit(addr, ADDR_CONTROL)) begin
      value = s.control & CTL_MASK;
    end else if (hit(addr, ADDR_FLAGS)) begin
      value[FLAG_OVF_BIT] = s.overflow_flag;
    end else if (hit(addr, ADDR_ENABLES)) begin
      value[ENA_OVF_BIT] = s.overflow_irq_enable;
    end else if (hit(addr, ADDR_CORE_IRQ)) begin
      value[CORE_GIE_BIT] = s.global_irq_enable;
      value[CORE_PERIPHERAL_IRQ_ENABLE_BIT] = s.peripheral_irq_enable;
    end
    read_mux = value;
  endfunction : read_mux

  // Control fields and the derived operating modes.
  assign counter_run         = state.control[CTL_RUN_BIT];
  assign clock_source_select = state.control[CTL_SRC_BIT];
  assign sync_disable        = state.control[CTL_SYNC_DIS_BIT];
  assign osc_enable          = state.control[CTL_OSC_EN_BIT];
  assign prescale_sel        = state.control[CTL_PS_HI_BIT:CTL_PS_LO_BIT];
  assign async_mode          = clock_source_select && sync_disable;
  assign ext_enabled         = counter_run && clock_source_select;
  assign count_hi            = state.count[15:8];

  // Register port write decode.
  assign write_lo    = reg_write && hit(reg_addr, ADDR_COUNT_LO);
  assign write_hi    = reg_write && hit(reg_addr, ADDR_COUNT_HI);
  assign write_count = write_lo || write_hi;

  // Count source selection and edge detection on the chosen pin.
  always_comb begin
    sel_pin  = osc_enable ? osc_input_pin : ext_count_pin;
    pin_rise = sel_pin && !state.pin_last;
    pin_fall = !sel_pin && state.pin_last;
    ext_tick = ext_enabled && (state.arm == ARM_READY) && pin_rise;
    instr_tick = counter_run && !clock_source_select && !sleep &&
                 (state.instr_phase == INSTR_LAST);
    pre_in = clock_source_select ? ext_tick : instr_tick;
  end

  // Prescaler ahead of the synchronizer; keeps counting external ticks in sleep.
  sbt_prescaler u_prescaler (
    .clock    (clock),
    .reset    (reset),
    .tick     (pre_in),
    .clear    (write_count),
    .select   (prescale_sel),
    .out_tick (pre_out)
  );

  // Increment selection and trigger qualification.
  always_comb begin
    if (async_mode) begin
      count_inc = pre_out;
    end else if (clock_source_select) begin
      count_inc = counter_run && state.sync_pipe[1]; // Stopping drops ticks still in flight.
    end else begin
      count_inc = pre_out;
    end
    trig_ok = !async_mode &&
              (unit_trigger(compare_mode_select_one, compare_unit_one_trigger) ||
               unit_trigger(compare_mode_select_two, compare_unit_two_trigger));
  end

  // Next-state logic for counter, registers and read data.
  always_comb begin
    next_state = state;
    next_state.pin_last = sel_pin;
    next_state.rdata = READ_IDLE;
    if (!sleep) begin
      next_state.instr_phase = state.instr_phase + 2'h1;
    end
    if (!ext_enabled) begin
      next_state.arm = ARM_WAIT_FALL;
    end else if (pin_fall) begin
      next_state.arm = ARM_READY;
    end
    if (sleep || async_mode) begin
      next_state.sync_pipe = 2'h0;
    end else begin
      next_state.sync_pipe = {state.sync_pipe[0], pre_out && clock_source_select};
    end
    if (write_count) begin
      if (write_lo) begin
        next_state.count[7:0] = reg_wdata;
      end else begin
        next_state.count[15:8] = reg_wdata;
      end
    end else if (trig_ok) begin
      next_state.count = COUNT_ZERO;
    end else if (count_inc) begin
      next_state.count = state.count + 16'h0001;
    end
    if (reg_write && hit(reg_addr, ADDR_CONTROL)) begin
      next_state.control = reg_wdata & CTL_MASK;
    end
    if (reg_write && hit(reg_addr, ADDR_ENABLES)) begin
      next_state.overflow_irq_enable = reg_wdata[ENA_OVF_BIT];
    end
    if (reg_write && hit(reg_addr, ADDR_CORE_IRQ)) begin
      next_state.global_irq_enable = reg_wdata[CORE_GIE_BIT];
      next_state.peripheral_irq_enable = reg_wdata[CORE_PERIPHERAL_IRQ_ENABLE_BIT];
    end
    if (reg_write && hit(reg_addr, ADDR_FLAGS)) begin
      next_state.overflow_flag = reg_wdata[FLAG_OVF_BIT];
    end
    // besides a flag write of one, only a real wrap sets the flag, and it wins over a flag write of zero but not over a reset
    if (count_inc && !trig_ok && !write_count && (state.count == COUNT_MAX)) begin
      next_state.overflow_flag = 1'b1;
    end
    if (reg_read) begin
      next_state.rdata = read_mux(reg_addr, state);
    end
    if (other_reset) begin
      next_state.overflow_flag = 1'b0;
      next_state.overflow_irq_enable = 1'b0;
      next_state.global_irq_enable = 1'b0;
      next_state.peripheral_irq_enable = 1'b0;
    end
    if (reset) begin
      next_state.control = CONTROL_RESET;
      next_state.overflow_flag = 1'b0;
      next_state.overflow_irq_enable = 1'b0;
      next_state.global_irq_enable = 1'b0;
      next_state.peripheral_irq_enable = 1'b0;
      next_state.instr_phase = 2'h0;
      next_state.pin_last = 1'b0;
      next_state.arm = ARM_WAIT_FALL;
      next_state.sync_pipe = 2'h0;
      next_state.rdata = READ_IDLE;
      next_state.count = state.count;
    end
  end

  // State register; reset is applied through the next-state logic.
  always_ff @(posedge clock) begin
    state <= next_state;
  end

  // Outputs toward the pins, compare units and interrupt controller.
  assign reg_rdata       = state.rdata;
  assign osc_amp_enable  = osc_enable;
  assign time_base_valid = !async_mode;
  assign time_base_count = state.count;
  assign overflow_irq    = state.overflow_flag && state.overflow_irq_enable &&
                           state.peripheral_irq_enable && state.global_irq_enable;
  assign wake_request    = state.overflow_flag && state.overflow_irq_enable;

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_sleeping;
    sleep ##1 sleep ##1 sleep;
  endsequence

  sequence s_wrap;
    count_inc && !trig_ok && !write_count && (state.count == COUNT_MAX);
  endsequence

  sequence s_sync_launch;
    clock_source_select && !sync_disable && !sleep && pre_out;
  endsequence

  sequence s_sync_carry;
    clock_source_select && !sync_disable && !sleep;
  endsequence

  a_write_low_wins: assert property (write_lo |=> state.count[7:0] == $past(reg_wdata))
    else $error("count low byte did not take the written value");

  a_trigger_clears: assert property (trig_ok && !write_count |=> state.count == COUNT_ZERO)
    else $error("trigger did not clear the count");

  a_trigger_no_flag: assert property (
      trig_ok && !state.overflow_flag && !(reg_write && hit(reg_addr, ADDR_FLAGS)) |=>
      !state.overflow_flag)
    else $error("trigger reset set the overflow flag");

  a_wrap_sets_flag: assert property (
      s_wrap ##0 !other_reset |=> state.overflow_flag && state.count == COUNT_ZERO)
    else $error("wrap did not latch the overflow flag");

  a_read_high_byte: assert property (
      reg_read && hit(reg_addr, ADDR_COUNT_HI) |=> reg_rdata == $past(count_hi))
    else $error("high byte read returned a wrong value");

  a_read_one_cycle: assert property (!reg_read |=> reg_rdata == READ_IDLE)
    else $error("read data stood beyond its cycle");

  a_por_control: assert property (
      disable iff (1'b0) reset |=> state.control == CONTROL_RESET)
    else $error("control not cleared by power-on reset");

  a_other_reset_keep: assert property (
      other_reset && !reg_write |=> state.control == $past(state.control))
    else $error("control changed on a non-power reset");

  a_sleep_holds: assert property (
      s_sleeping ##0 (clock_source_select && !sync_disable) |-> !count_inc)
    else $error("synchronized count advanced in sleep");

  a_instr_rate: assert property (instr_tick |=> !instr_tick [*3])
    else $error("instruction tick faster than one in four clocks");

  a_stop_freezes: assert property (
      !counter_run && !write_count && !trig_ok |=> state.count === $past(state.count))
    else $error("count moved while stopped");

  a_sync_two_stage: assert property (s_sync_launch ##1 s_sync_carry |=> state.sync_pipe[1])
    else $error("synchronized tick lost in the two-stage pipeline");

  a_arm_after_enable: assert property (!ext_enabled |=> !ext_tick)
    else $error("external tick counted before a falling edge");

  a_trigger_async: assert property (
      async_mode && !write_count && !count_inc |=> state.count === $past(state.count))
    else $error("trigger changed an unsynchronized count");

  a_async_sleep_counts: assert property (
      sleep && async_mode && pre_out && !write_count |=>
      state.count == $past(state.count) + 16'h0001)
    else $error("unsynchronized count stalled in sleep");

endmodule : sbt_timer

/* File: sbt_clock_source.sv */
// Model of the external clock source that drives both count pins of the timer/counter.
// Assumes the pins are pulled low by the board whenever no burst is being sent.
module sbt_clock_source (
  input  wire logic clock,
  output logic      ext_count_pin,
  output logic      osc_input_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // Both pins rest low between bursts, as the pull-downs leave them.
  initial begin
    ext_count_pin = 1'b0;
    osc_input_pin = 1'b0;
  end

  // Sends a burst of pulses on one pin, each high then low for half cycles.
  // first pulse arms: after enable the first pulse is not counted; its falling edge arms the counter.
  task automatic send(input bit use_osc, input int pulses, input int half);
    for (int i = 0; i < pulses; i++) begin
      @(posedge clock);
      ext_count_pin <= !use_osc;
      osc_input_pin <= use_osc;
      repeat (half) @(posedge clock);
      ext_count_pin <= 1'b0;
      osc_input_pin <= 1'b0;
      repeat (half - 1) @(posedge clock);
    end
  endtask : send
endmodule : sbt_clock_source

/* File: sbt_timer_tb_top.sv */
// Self-checking bench for the sixteen-bit timer/counter.
// Assumes the clock source model drives both count pins.
module sbt_timer_tb_top;
  import sbt_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clock = 1'b0;
  logic        reset, other_reset, sleep, reg_write, reg_read, trig_one, trig_two;
  logic        ext_pin, osc_pin, osc_amp, tb_valid, irq, wake;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [3:0]  mode_one, mode_two;
  logic [15:0] count, base;
  int          err_count = 0;
  int          tests_run = 0;

  // Core clock at 25 MHz.
  always #20 clock = ~clock;

  sbt_clock_source i_src (.clock(clock), .ext_count_pin(ext_pin), .osc_input_pin(osc_pin));

  sbt_timer i_dut (
    .clock(clock), .reset(reset), .other_reset(other_reset), .sleep(sleep),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .ext_count_pin(ext_pin),
    .osc_input_pin(osc_pin), .compare_mode_select_one(mode_one),
    .compare_unit_one_trigger(trig_one), .compare_mode_select_two(mode_two),
    .compare_unit_two_trigger(trig_two), .osc_amp_enable(osc_amp),
    .time_base_valid(tb_valid), .time_base_count(count), .overflow_irq(irq),
    .wake_request(wake)
  );

  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run;
    $display("Comparisons: %0d, mismatches: %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  // Compares a byte-wide result.
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_reg

  // Compares a sixteen-bit count result.
  task automatic chk_cnt(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_cnt

  // Waits whole cycles and lands just after the last edge.
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step

  // One-cycle register write.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr

  // One-cycle register read; data is taken in the cycle after the strobe.
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    chk_reg(reg_rdata, exp);
  endtask : rd_chk

  // Stops the counter, loads a count, then writes the final control value.
  task automatic load(input logic [7:0] ctl, input logic [15:0] v);
    wr(ADDR_CONTROL, ctl & 8'hfe);
    wr(ADDR_COUNT_LO, v[7:0]);
    wr(ADDR_COUNT_HI, v[15:8]);
    wr(ADDR_CONTROL, ctl);
    step(1);
  endtask : load

  // Pulses the power-on reset or the other reset for one cycle.
  task automatic pulse_reset(input bit power);
    @(posedge clock);
    reset       <= power;
    other_reset <= !power;
    @(posedge clock);
    reset       <= 1'b0;
    other_reset <= 1'b0;
    @(posedge clock);
    #1;
  endtask : pulse_reset

  // Raises one compare trigger, optionally with a low count byte write in the same cycle.
  task automatic trig(input bit two, input logic [3:0] m, input logic [7:0] lo, input bit w);
    @(posedge clock);
    mode_one  <= m;
    mode_two  <= m;
    trig_one  <= !two;
    trig_two  <= two;
    reg_addr  <= ADDR_COUNT_LO;
    reg_wdata <= lo;
    reg_write <= w;
    @(posedge clock);
    trig_one  <= 1'b0;
    trig_two  <= 1'b0;
    reg_write <= 1'b0;
    #1;
  endtask : trig

  // Cuts a hung run short.
  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    complete_run();
  end

  // Main test sequence.
  initial begin
    {reset, other_reset, sleep, reg_write, reg_read, trig_one, trig_two} = 7'h40;
    {reg_addr, reg_wdata, mode_one, mode_two} = 24'h0;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    step(1);
    rd_chk(ADDR_CONTROL, 8'h00);
    rd_chk(ADDR_FLAGS, 8'h00);
    rd_chk(ADDR_ENABLES, 8'h00);
    rd_chk(ADDR_CORE_IRQ, 8'h00);
    rd_chk(8'h55, 8'h00);
    wr(ADDR_CONTROL, 8'hfe);
    rd_chk(ADDR_CONTROL, 8'h3e);
    chk_reg({6'h0, osc_amp, tb_valid}, 8'h02);
    pulse_reset(1'b0);
    rd_chk(ADDR_CONTROL, 8'h3e);
    load(8'h00, 16'h1234);
    pulse_reset(1'b1);
    chk_cnt(count, 16'h1234);
    rd_chk(ADDR_COUNT_HI, 8'h12);
    rd_chk(ADDR_CONTROL, 8'h00);
    // Instruction clock through every prescale code, sync bit set to show it is ignored.
    for (int p = 0; p < 4; p++) begin
      load({2'h0, 2'(p), 4'h5}, 16'h0000);
      step(5);
      base = count;
      step(40 << p);
      chk_cnt(count - base, 16'h000a);
      chk_reg({7'h0, tb_valid}, 8'h01);
    end
    wr(ADDR_CONTROL, 8'h34);
    step(2);
    base = count;
    step(20);
    chk_cnt(count, base);
    // Wrap from the top count raises flag, wake and interrupt.
    wr(ADDR_ENABLES, 8'h01);
    wr(ADDR_CORE_IRQ, 8'hc0);
    load(8'h01, 16'hffff);
    for (int i = 0; i < 12 && count === 16'hffff; i++) step(1);
    chk_cnt(count, 16'h0000);
    wr(ADDR_CONTROL, 8'h00);
    step(1);
    chk_reg({6'h0, irq, wake}, 8'h03);
    rd_chk(ADDR_FLAGS, 8'h01);
    wr(ADDR_FLAGS, 8'h00);
    step(1);
    chk_reg({6'h0, irq, wake}, 8'h00);
    // Both compare units, with the trigger code and a neighbouring one.
    for (int u = 0; u < 2; u++) begin
      for (int m = 10; m < 12; m++) begin
        load(8'h00, 16'h1234);
        trig(u[0], 4'(m), 8'h00, 1'b0);
        chk_cnt(count, (m == 11) ? 16'h0000 : 16'h1234);
      end
    end
    rd_chk(ADDR_FLAGS, 8'h00);
    trig(1'b0, TRIGGER_MODE, 8'h77, 1'b1);
    chk_cnt(count, 16'h0077);
    load(8'h07, 16'h1234);
    trig(1'b0, TRIGGER_MODE, 8'h00, 1'b0);
    chk_cnt(count, 16'h1234);
    chk_reg({7'h0, tb_valid}, 8'h00);
    // Unsynchronized counting of the external pin, then of the oscillator pin.
    load(8'h07, 16'h0000);
    i_src.send(1'b0, 5, 2);
    step(6);
    chk_cnt(count, 16'h0004);
    rd_chk(ADDR_COUNT_LO, 8'h04);
    load(8'h0f, 16'h0000);
    step(50);
    i_src.send(1'b0, 3, 2);
    step(6);
    chk_cnt(count, 16'h0000);
    i_src.send(1'b1, 4, 2);
    step(6);
    chk_cnt(count, 16'h0003);
    // A count write in mid-prescale restarts the divide by eight.
    load(8'h37, 16'h0000);
    i_src.send(1'b0, 5, 2);
    load(8'h37, 16'h0040);
    i_src.send(1'b0, 7, 2);
    step(6);
    chk_cnt(count, 16'h0040);
    i_src.send(1'b0, 2, 2);
    step(6);
    chk_cnt(count, 16'h0041);
    // Synchronized divide by two: sleep drops the tick but the prescaler moves on.
    load(8'h13, 16'h0000);
    i_src.send(1'b0, 2, 3);
    @(posedge clock);
    sleep <= 1'b1;
    i_src.send(1'b0, 1, 3);
    repeat (6) @(posedge clock);
    sleep <= 1'b0;
    i_src.send(1'b0, 1, 3);
    step(6);
    chk_cnt(count, 16'h0000);
    i_src.send(1'b0, 1, 3);
    step(6);
    chk_cnt(count, 16'h0001);
    // Unsynchronized counting wraps and wakes the processor during sleep.
    load(8'h07, 16'hfffe);
    @(posedge clock);
    sleep <= 1'b1;
    i_src.send(1'b0, 3, 2);
    step(6);
    chk_cnt(count, 16'h0000);
    chk_reg({7'h0, wake}, 8'h01);
    sleep <= 1'b0;
    complete_run();
  end
endmodule : sbt_timer_tb_top
